/* dlfe_engine.v */
// Stack evaluator for discrete logic functions with per-instance state
//
// Summary of operation
// - and/or/xor take two to ten arguments
// - xor false when all arguments equal
// - not inverts its single argument
// - innermost first, results passed up stack
// - ten stored instances per stateful type
// - constants and state are unsigned 16-bit
// - rise true one cycle on false-to-true
// - fall true one cycle on true-to-false
// - time arguments count tenth-second units
// - clock true high interval, false low
// - clock starts in its true interval
// - counter reset clears, outputs false, ignores count
// - counter steps per rise, stops at target
// - counter hidden, restarts from zero
// - on-delay true after enable held target
// - off-delay true, falls target after enable
// - pulse timer starts on rise, ignores retrigger
// - pulse restarts only after a false cycle
// - latches hold, start reset, show state
// - set-dominant latch true when both asserted
// - reset-dominant latch false when both asserted
// - evaluation cycles nominally one tenth second
`timescale 1ns/100ps
`include "dlfe_defs.vh"

module dlfe_engine #(
	parameter TICK_CYCLES = `DLFE_TICK_CYCLES,
	parameter TICK_W = 22,
	parameter INSTANCES = `DLFE_INSTANCES,
	parameter STACK_DEPTH = `DLFE_STACK_DEPTH
) (
	input wire clk,
	input wire reset,
	input wire opValid,
	input wire [3:0] opCode,
	input wire [3:0] opIndex,
	input wire [3:0] opCount,
	input wire argValue,
	input wire [15:0] constA,
	input wire [15:0] constB,
	output reg opDone_reg,
	output reg resultBit_reg,
	output reg opError_reg,
	output reg [4:0] stackDepth_reg
);

	// Integer forms cut down on purpose to the counter and depth widths
	localparam integer TICK_LAST_I = TICK_CYCLES - 1;
	localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_I[TICK_W-1:0];
	localparam integer DEPTH_I = STACK_DEPTH;
	localparam [4:0] DEPTH5 = DEPTH_I[4:0];

	function [STACK_DEPTH-1:0] maskOf;
		input [4:0] n;
		integer k;
		begin
			maskOf = {STACK_DEPTH{1'b0}};
			for (k = 0; k < STACK_DEPTH; k = k + 1) begin
				if (k < n)
					maskOf[k] = 1'b1;
			end
		end
	endfunction

	reg [TICK_W-1:0] tickCnt_reg;
	reg tickPending_reg;
	reg cycleTick_reg;
	reg [STACK_DEPTH-1:0] stack_reg;
	reg [4:0] sp_reg;

	// Per-instance state, flip-flop arrays indexed by instance
	reg riseLast [0:INSTANCES-1];
	reg fallLast [0:INSTANCES-1];
	reg [15:0] clkPhase [0:INSTANCES-1];
	reg [15:0] upCount [0:INSTANCES-1];
	reg upClkLast [0:INSTANCES-1];
	reg [15:0] onDlyTime [0:INSTANCES-1];
	reg [15:0] offDlyTime [0:INSTANCES-1];
	reg [15:0] pulseTime [0:INSTANCES-1];
	reg pulsePwrLast [0:INSTANCES-1];
	reg pulseOutLast [0:INSTANCES-1];
	reg setLatch [0:INSTANCES-1];
	reg rstLatch [0:INSTANCES-1];

	wire tickNow = (tickCnt_reg == TICK_LAST);
	wire a0 = stack_reg[0];
	wire a1 = stack_reg[1];
	wire idxOk = (opIndex < INSTANCES);
	wire [3:0] idx = idxOk ? opIndex : 4'h0;

	reg res_next;
	reg err_next;
	reg [4:0] need;
	reg stateful;
	reg [15:0] word_next;
	reg bitA_next;
	reg bitB_next;
	reg [STACK_DEPTH-1:0] operands;
	reg [STACK_DEPTH-1:0] popped;
	reg [16:0] period;
	reg [16:0] phaseInc;
	reg pulseStart;

	always @* begin
		res_next = 1'b0;
		need = 5'h00;
		stateful = 1'b0;
		word_next = 16'h0000;
		bitA_next = 1'b0;
		bitB_next = 1'b0;
		operands = stack_reg & maskOf({1'b0, opCount});
		period = {1'b0, constA} + {1'b0, constB};
		phaseInc = {1'b0, clkPhase[idx]} + 17'h00001;
		pulseStart = 1'b0;
		err_next = 1'b0;
		case (opCode)
			`DLFE_OP_PUSH: begin
				res_next = argValue;
			end
			`DLFE_OP_AND: begin
				need = {1'b0, opCount};
				res_next = (operands == maskOf({1'b0, opCount}));
			end
			`DLFE_OP_OR: begin
				need = {1'b0, opCount};
				res_next = |operands;
			end
			`DLFE_OP_XOR: begin
				need = {1'b0, opCount};
				res_next = (operands != {STACK_DEPTH{1'b0}}) &&
					(operands != maskOf({1'b0, opCount}));
			end
			`DLFE_OP_NOT: begin
				need = 5'h01;
				res_next = !a0;
			end
			`DLFE_OP_RISE: begin
				need = 5'h01;
				stateful = 1'b1;
				bitA_next = a0;
				res_next = a0 && !riseLast[idx];
			end
			`DLFE_OP_FALL: begin
				need = 5'h01;
				stateful = 1'b1;
				bitA_next = a0;
				res_next = !a0 && fallLast[idx];
			end
			`DLFE_OP_CLOCK: begin
				stateful = 1'b1;
				// Phase zero after reset lands in the high interval
				res_next = (clkPhase[idx] < constA);
				word_next = clkPhase[idx];
				if (cycleTick_reg) begin
					if (phaseInc >= period)
						word_next = 16'h0000;
					else
						word_next = phaseInc[15:0];
				end
			end
			`DLFE_OP_UPCNT: begin
				// Stack holds count below reset
				need = 5'h02;
				stateful = 1'b1;
				bitA_next = a1;
				if (a0) begin
					word_next = 16'h0000;
					res_next = 1'b0;
				end else begin
					word_next = upCount[idx];
					// Holding at target keeps the count from wrapping
					if (a1 && !upClkLast[idx] && upCount[idx] != constA)
						word_next = upCount[idx] + 16'h0001;
					res_next = (word_next == constA);
				end
			end
			`DLFE_OP_ONDLY: begin
				need = 5'h01;
				stateful = 1'b1;
				if (!a0) begin
					word_next = 16'h0000;
				end else begin
					word_next = onDlyTime[idx];
					if (cycleTick_reg && onDlyTime[idx] < constA)
						word_next = onDlyTime[idx] + 16'h0001;
				end
				res_next = a0 && (word_next >= constA);
			end
			`DLFE_OP_OFFDLY: begin
				need = 5'h01;
				stateful = 1'b1;
				if (a0) begin
					word_next = constA;
				end else begin
					word_next = offDlyTime[idx];
					if (cycleTick_reg && offDlyTime[idx] != 16'h0000)
						word_next = offDlyTime[idx] - 16'h0001;
				end
				res_next = a0 || (word_next != 16'h0000);
			end
			`DLFE_OP_PULSE: begin
				need = 5'h01;
				stateful = 1'b1;
				bitA_next = a0;
				pulseStart = a0 && !pulsePwrLast[idx] && !pulseOutLast[idx];
				word_next = pulseTime[idx];
				if (pulseStart)
					word_next = constA;
				else if (cycleTick_reg && pulseTime[idx] != 16'h0000)
					word_next = pulseTime[idx] - 16'h0001;
				res_next = pulseStart || (word_next != 16'h0000);
				bitB_next = res_next;
			end
			`DLFE_OP_SETDOM: begin
				need = 5'h02;
				stateful = 1'b1;
				if (a1)
					res_next = 1'b1;
				else if (a0)
					res_next = 1'b0;
				else
					res_next = setLatch[idx];
				bitA_next = res_next;
			end
			`DLFE_OP_RSTDOM: begin
				need = 5'h02;
				stateful = 1'b1;
				if (a0)
					res_next = 1'b0;
				else if (a1)
					res_next = 1'b1;
				else
					res_next = rstLatch[idx];
				bitA_next = res_next;
			end
			`DLFE_OP_START: begin
				res_next = 1'b0;
			end
			default: begin
				err_next = 1'b1;
			end
		endcase
		if ((opCode == `DLFE_OP_AND || opCode == `DLFE_OP_OR || opCode == `DLFE_OP_XOR) &&
			(opCount < `DLFE_MIN_ARGS || opCount > `DLFE_MAX_ARGS))
			err_next = 1'b1;
		if (stateful && !idxOk)
			err_next = 1'b1;
		if (need > sp_reg)
			err_next = 1'b1;
		if (opCode != `DLFE_OP_START && (sp_reg - need) == DEPTH5)
			err_next = 1'b1;
		popped = stack_reg >> need;
	end

	integer i;

	always @(posedge clk) begin
		if (reset) begin
			tickCnt_reg <= {TICK_W{1'b0}};
			tickPending_reg <= 1'b0;
			cycleTick_reg <= 1'b0;
			stack_reg <= {STACK_DEPTH{1'b0}};
			sp_reg <= 5'h00;
			opDone_reg <= 1'b0;
			resultBit_reg <= 1'b0;
			opError_reg <= 1'b0;
			stackDepth_reg <= 5'h00;
			// All dynamic state restarts at zero
			for (i = 0; i < INSTANCES; i = i + 1) begin
				riseLast[i] <= 1'b0;
				fallLast[i] <= 1'b0;
				clkPhase[i] <= 16'h0000;
				upCount[i] <= 16'h0000;
				upClkLast[i] <= 1'b0;
				onDlyTime[i] <= 16'h0000;
				offDlyTime[i] <= 16'h0000;
				pulseTime[i] <= 16'h0000;
				pulsePwrLast[i] <= 1'b0;
				pulseOutLast[i] <= 1'b0;
				setLatch[i] <= 1'b0;
				rstLatch[i] <= 1'b0;
			end
		end else begin
			tickCnt_reg <= tickNow ? {TICK_W{1'b0}} : tickCnt_reg + 1'b1;
			opDone_reg <= opValid;
			if (opValid)
				opError_reg <= err_next;
			// A tick landing on the start op is kept for the next cycle
			if (opValid && !err_next && opCode == `DLFE_OP_START) begin
				cycleTick_reg <= tickPending_reg;
				tickPending_reg <= tickNow;
				stack_reg <= {STACK_DEPTH{1'b0}};
				sp_reg <= 5'h00;
				stackDepth_reg <= 5'h00;
				resultBit_reg <= 1'b0;
			end else begin
				if (tickNow)
					tickPending_reg <= 1'b1;
				if (opValid && !err_next) begin
					stack_reg <= {popped[STACK_DEPTH-2:0], res_next};
					sp_reg <= sp_reg - need + 5'h01;
					stackDepth_reg <= sp_reg - need + 5'h01;
					resultBit_reg <= res_next;
					case (opCode)
						`DLFE_OP_RISE: riseLast[idx] <= bitA_next;
						`DLFE_OP_FALL: fallLast[idx] <= bitA_next;
						`DLFE_OP_CLOCK: clkPhase[idx] <= word_next;
						`DLFE_OP_UPCNT: begin
							upCount[idx] <= word_next;
							upClkLast[idx] <= bitA_next;
						end
						`DLFE_OP_ONDLY: onDlyTime[idx] <= word_next;
						`DLFE_OP_OFFDLY: offDlyTime[idx] <= word_next;
						`DLFE_OP_PULSE: begin
							pulseTime[idx] <= word_next;
							pulsePwrLast[idx] <= bitA_next;
							pulseOutLast[idx] <= bitB_next;
						end
						`DLFE_OP_SETDOM: setLatch[idx] <= bitA_next;
						`DLFE_OP_RSTDOM: rstLatch[idx] <= bitA_next;
						default: begin
						end
					endcase
				end
			end
		end
	end

endmodule // dlfe_engine

/* dlfe_defs.vh */
// Constants for the discrete logic function engine
`ifndef DLFE_DEFS_VH
`define DLFE_DEFS_VH

`define DLFE_CLK_HZ 25000000
`define DLFE_TICK_MS 100
`define DLFE_TICK_CYCLES ((`DLFE_CLK_HZ / 1000) * `DLFE_TICK_MS)
`define DLFE_INSTANCES 10
`define DLFE_MIN_ARGS 2
`define DLFE_MAX_ARGS 10
`define DLFE_STACK_DEPTH 16

`define DLFE_OP_PUSH 4'h0
`define DLFE_OP_AND 4'h1
`define DLFE_OP_OR 4'h2
`define DLFE_OP_XOR 4'h3
`define DLFE_OP_NOT 4'h4
`define DLFE_OP_RISE 4'h5
`define DLFE_OP_FALL 4'h6
`define DLFE_OP_CLOCK 4'h7
`define DLFE_OP_UPCNT 4'h8
`define DLFE_OP_ONDLY 4'h9
`define DLFE_OP_OFFDLY 4'ha
`define DLFE_OP_PULSE 4'hb
`define DLFE_OP_SETDOM 4'hc
`define DLFE_OP_RSTDOM 4'hd
`define DLFE_OP_START 4'he

`endif

/* dlfe_engine_sva.sv */
// Port-level checks bound to the logic function engine
`timescale 1ns/100ps
module dlfe_engine_chk (
	input wire clk,
	input wire reset,
	input wire opValid,
	input wire [3:0] opCode,
	input wire [3:0] opIndex,
	input wire [3:0] opCount,
	input wire argValue,
	input wire [15:0] constA,
	input wire [15:0] constB,
	input wire opDone_reg,
	input wire resultBit_reg,
	input wire opError_reg,
	input wire [4:0] stackDepth_reg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic okOne;
	logic okTwo;
	logic multi;
	// Operands come from the top entry, which resultBit_reg mirrors
	assign okOne = opValid && stackDepth_reg != 5'h00 && opIndex < 4'ha;
	assign okTwo = okOne && stackDepth_reg > 5'h01;
	assign multi = opValid && opCode inside {4'h1, 4'h2, 4'h3};
	done_pulse_a: assert property (
		opValid |=> opDone_reg ##1 (!opDone_reg || $past(opValid)))
		else $error("done pulse wrong");
	push_top_a: assert property (
		opValid && opCode == 4'h0 && stackDepth_reg < 5'h10 |=>
		stackDepth_reg == $past(stackDepth_reg) + 5'h01 && resultBit_reg == $past(argValue))
		else $error("push wrong");
	arg_count_a: assert property (
		multi && (opCount < 4'h2 || opCount > 4'ha) |=> opError_reg && $stable(stackDepth_reg))
		else $error("bad count accepted");
	multi_pop_a: assert property (
		multi && opCount >= 4'h2 && opCount <= 4'ha && stackDepth_reg >= opCount |=>
		!opError_reg && stackDepth_reg == $past(stackDepth_reg) - $past(opCount) + 5'h01)
		else $error("operator stack use wrong");
	not_invert_a: assert property (
		okOne && opCode == 4'h4 |=> resultBit_reg == !$past(resultBit_reg) && $stable(stackDepth_reg))
		else $error("not wrong");
	index_range_a: assert property (
		opValid && opCode inside {[4'h5:4'hd]} && opIndex >= 4'ha |=> opError_reg)
		else $error("bad index accepted");
	start_clear_a: assert property (
		opValid && opCode == 4'he |=> stackDepth_reg == 5'h00 && !resultBit_reg)
		else $error("start did not clear");
	reset_wins_a: assert property (
		okTwo && opCode == 4'hd && resultBit_reg |=> !resultBit_reg)
		else $error("reset-dominant latch set");
	count_clear_a: assert property (
		okTwo && opCode == 4'h8 && resultBit_reg |=> !resultBit_reg)
		else $error("counter true in reset");
	ondly_off_a: assert property (
		okOne && opCode == 4'h9 && !resultBit_reg |=> !resultBit_reg)
		else $error("on-delay true unpowered");
	offdly_on_a: assert property (
		okOne && opCode == 4'ha && resultBit_reg |=> resultBit_reg)
		else $error("off-delay false powered");
endmodule // dlfe_engine_chk

/* dlfe_seq_model.sv */
// Equation sequencer model issuing operations to the engine
`timescale 1ns/100ps
module dlfe_seq_model (
	input wire clk,
	output logic opValid,
	output logic [3:0] opCode,
	output logic [3:0] opIndex,
	output logic [3:0] opCount,
	output logic argValue,
	output logic [15:0] constA,
	output logic [15:0] constB,
	input wire resultBit_reg,
	input wire opError_reg
);
	int idleGap = 0;
	logic res;
	logic err;
	initial {opValid, opCode, opIndex, opCount, argValue, constA, constB} = '0;
	// Counts and indices stay in range unless a refusal is wanted
	task op(input logic [3:0] c, input logic [3:0] i, input logic [3:0] n, input logic v,
		input logic [15:0] a);
		repeat (idleGap) @(posedge clk);
		@(posedge clk);
		{opValid, opCode, opIndex, opCount, argValue, constA, constB} <= {1'b1, c, i, n, v, a, 16'h0003};
		@(posedge clk);
		opValid <= 1'b0;
		// Stale argument must not look valid
		argValue <= ~v;
		#1;
		res = resultBit_reg;
		err = opError_reg;
	endtask
endmodule // dlfe_seq_model

/* testbench.sv */
// Self-checking bench for the discrete logic function engine
`timescale 1ns/100ps
module testbench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	wire opValid, argValue, opDone_reg, resultBit_reg, opError_reg;
	wire [3:0] opCode, opIndex, opCount;
	wire [15:0] constA, constB;
	wire [4:0] stackDepth_reg;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	always @(posedge clk) cyc <= reset ? 0 : cyc + 1;
	dlfe_engine #(.TICK_CYCLES(20)) i_dut (.clk(clk), .reset(reset), .opValid(opValid),
		.opCode(opCode), .opIndex(opIndex), .opCount(opCount), .argValue(argValue),
		.constA(constA), .constB(constB), .opDone_reg(opDone_reg), .resultBit_reg(resultBit_reg),
		.opError_reg(opError_reg), .stackDepth_reg(stackDepth_reg));
	dlfe_seq_model i_seq (.clk(clk), .opValid(opValid), .opCode(opCode), .opIndex(opIndex),
		.opCount(opCount), .argValue(argValue), .constA(constA), .constB(constB),
		.resultBit_reg(resultBit_reg), .opError_reg(opError_reg));
	task stop_test;
		$display("Checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	task p(input logic v);
		i_seq.op(4'h0, 4'h0, 4'h0, v, 16'h0000);
	endtask
	task f(input logic [3:0] c, input logic [3:0] i, input logic [3:0] n, input logic e);
		i_seq.op(c, i, n, 1'b0, 16'h0002);
		chk(e, i_seq.res);
		chk(1'b0, i_seq.err);
	endtask
	task do_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
	endtask
	task t_logic;
		f(4'he, 4'h0, 4'h0, 1'b0);
		p(1'b1);
		p(1'b0);
		p(1'b1);
		f(4'h2, 4'h0, 4'h2, 1'b1);
		f(4'h1, 4'h0, 4'h2, 1'b1);
		repeat (10) p(1'b1);
		f(4'h3, 4'h0, 4'ha, 1'b0);
		p(1'b1);
		f(4'h3, 4'h0, 4'h2, 1'b1);
		f(4'h4, 4'h0, 4'h0, 1'b0);
		i_seq.op(4'h1, 4'h0, 4'h1, 1'b0, 16'h0000);
		chk(1'b1, i_seq.err);
		i_seq.op(4'h2, 4'h0, 4'hb, 1'b0, 16'h0000);
		chk(1'b1, i_seq.err);
		i_seq.op(4'h5, 4'ha, 4'h0, 1'b0, 16'h0000);
		chk(1'b1, i_seq.err);
	endtask
	// One count-input rise per evaluation keeps the pulse rate legal
	task t_state;
		logic [6:0] v, s, r, c, q;
		v = 7'b0000110;
		s = 7'b0001010;
		r = 7'b0011000;
		c = 7'b1110101;
		q = 7'b0100000;
		for (int i = 0; i < 7; i++) begin
			f(4'he, 4'h0, 4'h0, 1'b0);
			p(v[i]);
			f(4'h5, 4'h3, 4'h0, i == 1);
			p(v[i]);
			f(4'h6, 4'h3, 4'h0, i == 3);
			p(s[i]);
			p(r[i]);
			f(4'hc, 4'h2, 4'h0, i > 0 && i < 4);
			p(s[i]);
			p(r[i]);
			f(4'hd, 4'h2, 4'h0, i == 1 || i == 2);
			p(c[i]);
			p(q[i]);
			f(4'h8, 4'h9, 4'h0, i > 1 && i < 5);
		end
	endtask
	task t_timers;
		logic [6:0] on, off, pw;
		int k;
		on = 7'b0001111;
		off = 7'b0010001;
		pw = 7'b1011010;
		do_reset();
		for (int i = 0; i < 7; i++) begin
			k = 0;
			// Fixed phase gives exactly one tick between evaluations
			while (cyc % 20 != 10 && k < 100) begin
				@(posedge clk);
				#1;
				k++;
			end
			if (k == 100) begin
				failures++;
				$display("MISMATCH at %0t: tick phase not reached", $time);
				stop_test();
			end
			f(4'he, 4'h0, 4'h0, 1'b0);
			// Result uses the phase held before this cycle's tick step
			f(4'h7, 4'h1, 4'h0, i < 3 || i == 6);
			p(on[i]);
			f(4'h9, 4'h0, 4'h0, i == 2 || i == 3);
			p(off[i]);
			f(4'ha, 4'h0, 4'h0, i < 2 || i == 4 || i == 5);
			p(pw[i]);
			f(4'hb, 4'h0, 4'h0, i == 1 || i == 2 || i == 6);
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_logic();
		i_seq.idleGap = 1;
		t_state();
		i_seq.idleGap = 0;
		t_timers();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("MISMATCH at %0t: run timed out", $time);
		stop_test();
	end
endmodule // testbench
bind dlfe_engine dlfe_engine_chk i_chk (.clk(clk), .reset(reset), .opValid(opValid),
	.opCode(opCode), .opIndex(opIndex), .opCount(opCount), .argValue(argValue),
	.constA(constA), .constB(constB), .opDone_reg(opDone_reg), .resultBit_reg(resultBit_reg),
	.opError_reg(opError_reg), .stackDepth_reg(stackDepth_reg));
